// ### pkg/sea_pkg.sv
/*
 * sea_pkg: constants, register map and carrier types of the wake and
 * management event aggregator. Assumes an 8-bit register port and one clock.
 */
`default_nettype none
package sea_pkg;
	// ==========================================================
	// sizes
	localparam int SEA_NGPIO = 8;
	localparam int SEA_NTACH = 2;
	localparam int SEA_NWAKE = 5;
	localparam int SEA_NPER = 6;
	localparam int SEA_NPIN = SEA_NGPIO + SEA_NTACH + SEA_NWAKE;
	localparam int SEA_NSTK = SEA_NWAKE + 2 * SEA_NGPIO + 2 * SEA_NTACH + SEA_NGPIO;
	localparam logic [SEA_NGPIO-1:0] SEA_EE_CAPABLE_RST = 8'h3c;
	// ==========================================================
	// register offsets
	localparam logic [7:0] SEA_WAKE_ST_ONE = 8'h00;
	localparam logic [7:0] SEA_WAKE_EN_ONE = 8'h01;
	localparam logic [7:0] SEA_WAKE_GLOBAL = 8'h02;
	localparam logic [7:0] SEA_WAKE_ST_GPIO = 8'h03;
	localparam logic [7:0] SEA_WAKE_EN_GPIO = 8'h04;
	localparam logic [7:0] SEA_WAKE_ST_THREE = 8'h05;
	localparam logic [7:0] SEA_WAKE_EN_THREE = 8'h06;
	localparam logic [7:0] SEA_MGMT_ST_ONE = 8'h07;
	localparam logic [7:0] SEA_MGMT_EN_ONE = 8'h08;
	localparam logic [7:0] SEA_MGMT_ST_TWO = 8'h09;
	localparam logic [7:0] SEA_MGMT_EN_TWO = 8'h0a;
	localparam logic [7:0] SEA_MGMT_ST_GPIO = 8'h0b;
	localparam logic [7:0] SEA_MGMT_EN_GPIO = 8'h0c;
	localparam logic [7:0] SEA_MGMT_ST_TACH = 8'h0d;
	localparam logic [7:0] SEA_MGMT_EN_TACH = 8'h0e;
	localparam logic [7:0] SEA_MISC_ST = 8'h0f;
	localparam logic [7:0] SEA_GPIO_CFG = 8'h10;
	localparam logic [7:0] SEA_GPIO_DATA = 8'h18;
	localparam logic [7:0] SEA_MGMT_PIN_CFG = 8'h19;
	localparam logic [7:0] SEA_WAKE_PIN_CFG = 8'h1a;
	// ==========================================================
	// field positions
	localparam int SEA_CFG_DIR = 0;
	localparam int SEA_CFG_POL = 1;
	localparam int SEA_CFG_EE = 2;
	localparam int SEA_CFG_FSEL = 0;
	localparam int SEA_CFG_PUSH = 7;
	localparam int SEA_GLB_EN = 0;
	localparam int SEA_GLB_ST = 1;
	localparam int SEA_EN2_IR = 0;
	localparam int SEA_EN2_WAKE = 5;
	localparam int SEA_EN2_SIRQ = 6;
	localparam int SEA_EN2_PIN = 7;
	localparam int SEA_ST3_ROUTED = 3;
	// ==========================================================
	// reset values
	localparam logic [7:0] SEA_GPIO_CFG_RST = 8'h01;
	localparam logic [7:0] SEA_PIN_CFG_RST = 8'h01;
	localparam logic [7:0] SEA_REG_RST = 8'h00;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic o;
		logic oe;
	} sea_pin_type;
	typedef struct packed {
		logic [7:0] rdata;
		logic [7:0] wake_en_one;
		logic wake_gen;
		logic wake_gst;
		logic [7:0] wake_en_gpio;
		logic [7:0] wake_en_three;
		logic [7:0] mgmt_en_one;
		logic [7:0] mgmt_en_two;
		logic [7:0] mgmt_en_gpio;
		logic [7:0] mgmt_en_tach;
		logic [SEA_NGPIO-1:0][7:0] cfg;
		logic [7:0] mgmt_cfg;
		logic [7:0] wake_cfg;
		logic ir_st;
		logic routed_st;
		logic group;
		logic serirq;
		sea_pin_type mgmt_pin;
		sea_pin_type wake_pin;
	} sea_state_type;
endpackage : sea_pkg
`default_nettype wire

// ### src/sea_edge.sv
/*
 * sea_edge: two-stage synchroniser and edge detector for a group of pins.
 * Assumes the pins are asynchronous to i_clk and held at least two cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module sea_edge #(
	parameter int W = 4
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_level,
	output logic [W-1:0] o_rise,
	output logic [W-1:0] o_fall
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] last;
	} edge_type;
	edge_type st_r;
	edge_type st_nxt;
	// ==========================================================
	// first stage feeds only the second
	always_comb begin
		st_nxt.meta = i_pin;
		st_nxt.sync = st_r.meta;
		st_nxt.last = st_r.sync;
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign o_level = st_r.last;
	assign o_rise = st_r.sync & ~st_r.last;
	assign o_fall = ~st_r.sync & st_r.last;
endmodule : sea_edge
`default_nettype wire

// ### src/sea_sticky.sv
/*
 * sea_sticky: bank of sticky status bits, write-one-to-clear.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sea_sticky #(
	parameter int W = 8
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [W-1:0] i_set,
	input wire logic [W-1:0] i_clr,
	output logic [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] q;
	} sticky_type;
	sticky_type st_r;
	sticky_type st_nxt;
	// ==========================================================
	// set beats clear so no event is lost
	always_comb begin
		st_nxt.q = (st_r.q & ~i_clr) | i_set;
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign o_q = st_r.q;
endmodule : sea_sticky
`default_nettype wire

// ### src/sea_aggregator.sv
/*
 * sea_aggregator: wake and management event aggregator with its registers.
 * Assumes a same-clock register port, async pins and same-clock peripheral
 * requests that stay high until their source clears them.
 */
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sea_aggregator
	import sea_pkg::*;
#(
	parameter logic [SEA_NGPIO-1:0] EE_CAPABLE = SEA_EE_CAPABLE_RST
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic [SEA_NGPIO-1:0] i_gpio_pin,
	input wire logic [SEA_NTACH-1:0] i_tach_pin,
	input wire logic [SEA_NWAKE-1:0] i_wake_pin,
	input wire logic [SEA_NPER-1:0] i_periph_req,
	input wire logic i_infrared_event,
	output logic o_group_mgmt_internal,
	output logic o_serirq_irq2,
	output sea_pin_type o_mgmt_irq_pin,
	output sea_pin_type o_wake_event_pin
);
	// ==========================================================
	// decode helpers
	function automatic logic sea_hit(input logic [7:0] addr, input logic [7:0] off);
		return addr == off;
	endfunction : sea_hit

	// open drain drives only the low level
	function automatic sea_pin_type sea_drive(input logic active, input logic [7:0] cfg);
		sea_pin_type p;
		logic level;
		level = cfg[SEA_CFG_POL] ? active : ~active;
		p.o = cfg[SEA_CFG_PUSH] ? level : 1'b0;
		p.oe = cfg[SEA_CFG_FSEL] & (cfg[SEA_CFG_PUSH] | ~level);
		return p;
	endfunction : sea_drive

	sea_state_type st_r;
	sea_state_type st_nxt;

	// ==========================================================
	// synchronised pins
	logic [SEA_NPIN-1:0] pin_lvl;
	logic [SEA_NPIN-1:0] pin_rise;
	logic [SEA_NPIN-1:0] pin_fall;

	sea_edge #(
		.W(SEA_NPIN)
	) u_edge (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_pin({i_wake_pin, i_tach_pin, i_gpio_pin}),
		.o_level(pin_lvl),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	logic [SEA_NGPIO-1:0] gp_lvl;
	logic [SEA_NGPIO-1:0] gp_rise;
	logic [SEA_NGPIO-1:0] gp_fall;
	logic [SEA_NTACH-1:0] tach_rise;
	logic [SEA_NWAKE-1:0] wsrc_rise;

	assign gp_lvl = pin_lvl[SEA_NGPIO-1:0];
	assign gp_rise = pin_rise[SEA_NGPIO-1:0];
	assign gp_fall = pin_fall[SEA_NGPIO-1:0];
	assign tach_rise = pin_rise[SEA_NGPIO+SEA_NTACH-1:SEA_NGPIO];
	assign wsrc_rise = pin_rise[SEA_NPIN-1:SEA_NGPIO+SEA_NTACH];

	// ==========================================================
	// gpio events
	logic [SEA_NGPIO-1:0] gp_ev;
	logic [SEA_NGPIO-1:0] misc_ev;
	logic [SEA_NGPIO-1:0] gp_data;

	genvar g;
	generate
		for (g = 0; g < SEA_NGPIO; g++) begin : g_gpio
			logic pol;
			logic dir_in;
			logic ee;
			assign pol = st_r.cfg[g][SEA_CFG_POL];
			assign dir_in = st_r.cfg[g][SEA_CFG_DIR];
			assign ee = EE_CAPABLE[g] & st_r.cfg[g][SEA_CFG_EE];
			// either-edge ignores direction and polarity
			assign gp_ev[g] = ee ? (gp_rise[g] | gp_fall[g]) :
				(dir_in & (pol ? gp_fall[g] : gp_rise[g]));
			// misc flags track every edge of capable pins
			assign misc_ev[g] = EE_CAPABLE[g] & (gp_rise[g] | gp_fall[g]);
			assign gp_data[g] = gp_lvl[g] ^ pol;
		end
	endgenerate

	// ==========================================================
	// sticky status banks
	logic [SEA_NSTK-1:0] stk_set;
	logic [SEA_NSTK-1:0] stk_clr;
	logic [SEA_NSTK-1:0] stk_q;
	logic [SEA_NWAKE-1:0] wake_st_one;
	logic [SEA_NGPIO-1:0] wake_st_gpio;
	logic [SEA_NTACH-1:0] wake_st_tach;
	logic [SEA_NGPIO-1:0] mgmt_st_gpio;
	logic [SEA_NTACH-1:0] mgmt_st_tach;
	logic [SEA_NGPIO-1:0] misc_st;

	// statuses set with no regard to enables
	assign stk_set = {misc_ev, tach_rise, gp_ev, tach_rise, gp_ev, wsrc_rise};

	assign {misc_st, mgmt_st_tach, mgmt_st_gpio, wake_st_tach, wake_st_gpio, wake_st_one} = stk_q;

	logic wr_wst1;
	logic wr_wstg;
	logic wr_wst3;
	logic wr_mstg;
	logic wr_mstt;
	logic wr_misc;

	assign wr_wst1 = i_wr & sea_hit(i_addr, SEA_WAKE_ST_ONE);
	assign wr_wstg = i_wr & sea_hit(i_addr, SEA_WAKE_ST_GPIO);
	assign wr_wst3 = i_wr & sea_hit(i_addr, SEA_WAKE_ST_THREE);
	assign wr_mstg = i_wr & sea_hit(i_addr, SEA_MGMT_ST_GPIO);
	assign wr_mstt = i_wr & sea_hit(i_addr, SEA_MGMT_ST_TACH);
	assign wr_misc = i_wr & sea_hit(i_addr, SEA_MISC_ST);

	assign stk_clr = {
		{SEA_NGPIO{wr_misc}} & i_wdata[SEA_NGPIO-1:0],
		{SEA_NTACH{wr_mstt}} & i_wdata[SEA_NTACH-1:0],
		{SEA_NGPIO{wr_mstg}} & i_wdata[SEA_NGPIO-1:0],
		{SEA_NTACH{wr_wst3}} & i_wdata[SEA_NTACH-1:0],
		{SEA_NGPIO{wr_wstg}} & i_wdata[SEA_NGPIO-1:0],
		{SEA_NWAKE{wr_wst1}} & i_wdata[SEA_NWAKE-1:0]
	};

	sea_sticky #(
		.W(SEA_NSTK)
	) u_sticky (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_set(stk_set),
		.i_clr(stk_clr),
		.o_q(stk_q)
	);

	// ==========================================================
	// group management signal
	logic per_any;
	logic gpio_any;
	logic group;

	// peripheral requests combine live with enables
	assign per_any = |(i_periph_req & st_r.mgmt_en_one[SEA_NPER-1:0]) |
		(st_r.ir_st & st_r.mgmt_en_two[SEA_EN2_IR]);
	assign gpio_any = |(mgmt_st_gpio & st_r.mgmt_en_gpio[SEA_NGPIO-1:0]) |
		|(mgmt_st_tach & st_r.mgmt_en_tach[SEA_NTACH-1:0]);
	assign group = per_any | gpio_any;

	// ==========================================================
	// wake logic
	logic wake_pend;
	logic wake_new;
	logic routed_set;

	assign routed_set = group & st_r.mgmt_en_two[SEA_EN2_WAKE];

	assign wake_pend = |(wake_st_one & st_r.wake_en_one[SEA_NWAKE-1:0]) |
		|(wake_st_gpio & st_r.wake_en_gpio[SEA_NGPIO-1:0]) |
		|(wake_st_tach & st_r.wake_en_three[SEA_NTACH-1:0]) |
		(st_r.routed_st & st_r.wake_en_three[SEA_ST3_ROUTED]);

	// only fresh transitions of enabled sources set global status
	assign wake_new = |(wsrc_rise & st_r.wake_en_one[SEA_NWAKE-1:0]) |
		|(gp_ev & st_r.wake_en_gpio[SEA_NGPIO-1:0]) |
		|(tach_rise & st_r.wake_en_three[SEA_NTACH-1:0]) |
		(routed_set & ~st_r.routed_st & st_r.wake_en_three[SEA_ST3_ROUTED]);

	// ==========================================================
	// next state
	always_comb begin
		st_nxt = st_r;

		// register writes
		if (i_wr) begin
			unique case (i_addr)
				SEA_WAKE_EN_ONE: begin
					st_nxt.wake_en_one = i_wdata;
				end
				SEA_WAKE_EN_GPIO: begin
					st_nxt.wake_en_gpio = i_wdata;
				end
				SEA_WAKE_EN_THREE: begin
					st_nxt.wake_en_three = i_wdata;
				end
				SEA_MGMT_EN_ONE: begin
					st_nxt.mgmt_en_one = i_wdata;
				end
				SEA_MGMT_EN_TWO: begin
					st_nxt.mgmt_en_two = i_wdata;
				end
				SEA_MGMT_EN_GPIO: begin
					st_nxt.mgmt_en_gpio = i_wdata;
				end
				SEA_MGMT_EN_TACH: begin
					st_nxt.mgmt_en_tach = i_wdata;
				end
				SEA_MGMT_PIN_CFG: begin
					st_nxt.mgmt_cfg = i_wdata;
				end
				SEA_WAKE_PIN_CFG: begin
					st_nxt.wake_cfg = i_wdata;
				end
				SEA_WAKE_GLOBAL: begin
					st_nxt.wake_gen = i_wdata[SEA_GLB_EN];
				end
				default: begin
				end
			endcase
			for (int k = 0; k < SEA_NGPIO; k++) begin
				if (sea_hit(i_addr, SEA_GPIO_CFG + 8'(k))) begin
					st_nxt.cfg[k] = i_wdata;
				end
			end
		end

		// global wake status: clear refused while any enabled status pends
		if (i_wr && sea_hit(i_addr, SEA_WAKE_GLOBAL) && i_wdata[SEA_GLB_ST] && !wake_pend) begin
			st_nxt.wake_gst = 1'b0;
		end
		if (wake_new) begin
			st_nxt.wake_gst = 1'b1;
		end

		// routed status: write-one clears, still-active source re-sets
		if (wr_wst3 && i_wdata[SEA_ST3_ROUTED]) begin
			st_nxt.routed_st = 1'b0;
		end
		if (routed_set) begin
			st_nxt.routed_st = 1'b1;
		end

		// infrared flag clears on a read of status two
		if (i_rd && sea_hit(i_addr, SEA_MGMT_ST_TWO)) begin
			st_nxt.ir_st = 1'b0;
		end
		if (i_infrared_event) begin
			st_nxt.ir_st = 1'b1;
		end

		// read data stands one cycle only
		st_nxt.rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				SEA_WAKE_ST_ONE: begin
					st_nxt.rdata = 8'(wake_st_one);
				end
				SEA_WAKE_EN_ONE: begin
					st_nxt.rdata = st_r.wake_en_one;
				end
				SEA_WAKE_GLOBAL: begin
					st_nxt.rdata = {6'h00, st_r.wake_gst, st_r.wake_gen};
				end
				SEA_WAKE_ST_GPIO: begin
					st_nxt.rdata = 8'(wake_st_gpio);
				end
				SEA_WAKE_EN_GPIO: begin
					st_nxt.rdata = st_r.wake_en_gpio;
				end
				SEA_WAKE_ST_THREE: begin
					st_nxt.rdata = {4'h0, st_r.routed_st, 1'b0, wake_st_tach};
				end
				SEA_WAKE_EN_THREE: begin
					st_nxt.rdata = st_r.wake_en_three;
				end
				SEA_MGMT_ST_ONE: begin
					st_nxt.rdata = 8'(i_periph_req);
				end
				SEA_MGMT_EN_ONE: begin
					st_nxt.rdata = st_r.mgmt_en_one;
				end
				SEA_MGMT_ST_TWO: begin
					st_nxt.rdata = {7'h00, st_r.ir_st};
				end
				SEA_MGMT_EN_TWO: begin
					st_nxt.rdata = st_r.mgmt_en_two;
				end
				SEA_MGMT_ST_GPIO: begin
					st_nxt.rdata = 8'(mgmt_st_gpio);
				end
				SEA_MGMT_EN_GPIO: begin
					st_nxt.rdata = st_r.mgmt_en_gpio;
				end
				SEA_MGMT_ST_TACH: begin
					st_nxt.rdata = 8'(mgmt_st_tach);
				end
				SEA_MGMT_EN_TACH: begin
					st_nxt.rdata = st_r.mgmt_en_tach;
				end
				SEA_MISC_ST: begin
					st_nxt.rdata = 8'(misc_st);
				end
				SEA_GPIO_DATA: begin
					st_nxt.rdata = 8'(gp_data);
				end
				SEA_MGMT_PIN_CFG: begin
					st_nxt.rdata = st_r.mgmt_cfg;
				end
				SEA_WAKE_PIN_CFG: begin
					st_nxt.rdata = st_r.wake_cfg;
				end
				default: begin
					st_nxt.rdata = 8'h00;
				end
			endcase
			for (int k = 0; k < SEA_NGPIO; k++) begin
				if (sea_hit(i_addr, SEA_GPIO_CFG + 8'(k))) begin
					st_nxt.rdata = st_r.cfg[k];
				end
			end
		end

		// outputs, registered so pins never glitch
		st_nxt.group = group;
		st_nxt.serirq = group & st_r.mgmt_en_two[SEA_EN2_SIRQ];
		st_nxt.mgmt_pin = sea_drive(group & st_r.mgmt_en_two[SEA_EN2_PIN], st_r.mgmt_cfg);
		st_nxt.wake_pin = sea_drive(st_r.wake_gen & wake_pend, st_r.wake_cfg);
	end

	// ==========================================================
	// state register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= '0;
			st_r.cfg <= {SEA_NGPIO{SEA_GPIO_CFG_RST}};
			st_r.mgmt_cfg <= SEA_PIN_CFG_RST;
			st_r.wake_cfg <= SEA_PIN_CFG_RST;
			st_r.mgmt_pin.oe <= 1'b0;
			st_r.wake_pin.oe <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign o_rdata = st_r.rdata;
	assign o_group_mgmt_internal = st_r.group;
	assign o_serirq_irq2 = st_r.serirq;
	assign o_mgmt_irq_pin = st_r.mgmt_pin;
	assign o_wake_event_pin = st_r.wake_pin;

endmodule : sea_aggregator
`default_nettype wire

// ### tb/sea_aggregator_props.sv
/*
 * sea_aggregator_props: port checker for the event aggregator.
 * Assumes bench register writes are the only source of pin and routing config.
 */
`timescale 1ns/1ps
`default_nettype none
module sea_aggregator_props
	import sea_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_group_mgmt_internal,
	input wire logic o_serirq_irq2,
	input wire sea_pin_type o_mgmt_irq_pin,
	input wire sea_pin_type o_wake_event_pin
);
	// ==========================================================
	// config shadows, tracked from the write strobe
	logic [7:0] en2_r;
	logic [7:0] mcfg_r;
	logic [7:0] wcfg_r;
	logic gen_r;
	logic grp_r;
	logic [1:0] quiet_r;
	logic [7:0] shd;
	logic rd_cfg;
	logic quiet;
	logic grp_hi;
	logic grp_lo;
	function automatic sea_pin_type drive(input logic act, input logic [7:0] cfg);
		logic lvl;
		lvl = cfg[SEA_CFG_POL] ? act : ~act;
		drive.o = cfg[SEA_CFG_PUSH] & lvl;
		drive.oe = cfg[SEA_CFG_FSEL] & (cfg[SEA_CFG_PUSH] | ~lvl);
	endfunction : drive
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			en2_r <= 8'h00;
			mcfg_r <= 8'h01;
			wcfg_r <= 8'h01;
			gen_r <= 1'b0;
			grp_r <= 1'b0;
			quiet_r <= 2'h0;
		end else begin
			grp_r <= o_group_mgmt_internal;
			quiet_r <= i_wr ? 2'h0 : (quiet_r == 2'h3 ? quiet_r : quiet_r + 2'h1);
			if (i_wr && i_addr == SEA_MGMT_EN_TWO) en2_r <= i_wdata;
			if (i_wr && i_addr == SEA_MGMT_PIN_CFG) mcfg_r <= i_wdata;
			if (i_wr && i_addr == SEA_WAKE_PIN_CFG) wcfg_r <= i_wdata;
			if (i_wr && i_addr == SEA_WAKE_GLOBAL) gen_r <= i_wdata[SEA_GLB_EN];
		end
	end
	always_comb begin
		shd = (i_addr == SEA_MGMT_EN_TWO) ? en2_r : (i_addr == SEA_MGMT_PIN_CFG) ? mcfg_r : wcfg_r;
		rd_cfg = i_rd && (i_addr == SEA_MGMT_EN_TWO || i_addr == SEA_MGMT_PIN_CFG
			|| i_addr == SEA_WAKE_PIN_CFG);
		quiet = quiet_r == 2'h3;
		grp_hi = o_group_mgmt_internal && grp_r;
		grp_lo = !o_group_mgmt_internal && !grp_r;
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not zero outside the read slot");
	a_rdata_cfg: assert property ($past(rd_cfg) |-> o_rdata == $past(shd))
		else $error("config readback differs from last write");
	a_reset_pins: assert property ($rose(i_reset_n) |-> o_mgmt_irq_pin == 2'b00
		&& o_wake_event_pin == 2'b00)
		else $error("pins not released after reset");
	a_mgmt_pin_on: assert property (quiet && grp_hi |-> o_mgmt_irq_pin == drive(en2_r[7], mcfg_r))
		else $error("management pin drive wrong while group active");
	// pin lags a config write by one cycle, so compare with the earlier shadow
	a_mgmt_pin_off: assert property (grp_lo ##1 grp_lo |-> o_mgmt_irq_pin == drive(1'b0, $past(mcfg_r)))
		else $error("management pin drive wrong while group idle");
	a_irq2_on: assert property (quiet && grp_hi |-> o_serirq_irq2 == en2_r[6])
		else $error("irq2 slot does not follow its enable");
	a_irq2_off: assert property (grp_lo |-> !o_serirq_irq2)
		else $error("irq2 slot active without group signal");
	a_wake_gated: assert property (quiet && !gen_r |-> o_wake_event_pin == drive(1'b0, wcfg_r))
		else $error("wake pin active with global enable clear");
	c_grp_pin: cover property (grp_hi && en2_r[7]);
	c_irq2: cover property (o_serirq_irq2);
	c_wake: cover property (gen_r && o_wake_event_pin != drive(1'b0, wcfg_r));
endmodule : sea_aggregator_props
`default_nettype wire

// ### tb/sea_host_model.sv
/*
 * sea_host_model: chipset side of the two group pins.
 * Assumes board pull-ups on both lines, so a released pin reads high.
 */
`timescale 1ns/1ps
`default_nettype none
module sea_host_model
	import sea_pkg::*;
(
	input wire sea_pin_type i_mgmt_pin,
	input wire sea_pin_type i_wake_pin,
	output logic o_mgmt_line,
	output logic o_wake_line
);
	// pull-up wins only while no driver is enabled
	assign o_mgmt_line = i_mgmt_pin.oe ? i_mgmt_pin.o : 1'b1;
	assign o_wake_line = i_wake_pin.oe ? i_wake_pin.o : 1'b1;
endmodule : sea_host_model
`default_nettype wire

// ### tb/sea_aggregator_bench.sv
/*
 * sea_aggregator_bench: register-call tests of the event aggregator.
 * Assumes the package map and a host model resolving the pins.
 */
`timescale 1ns/1ps
`default_nettype none
module sea_aggregator_bench;
	import sea_pkg::*;
	logic i_clk;
	logic i_reset_n;
	logic [7:0] i_addr;
	logic [7:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [7:0] o_rdata;
	logic [SEA_NGPIO-1:0] i_gpio_pin;
	logic [SEA_NTACH-1:0] i_tach_pin;
	logic [SEA_NWAKE-1:0] i_wake_pin;
	logic [SEA_NPER-1:0] i_periph_req;
	logic i_infrared_event;
	logic o_group_mgmt_internal;
	logic o_serirq_irq2;
	sea_pin_type o_mgmt_irq_pin;
	sea_pin_type o_wake_event_pin;
	logic mgmt_line;
	logic wake_line;
	int n_fail;
	int total_checks;
	int cyc;
	sea_aggregator DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_gpio_pin(i_gpio_pin), .i_tach_pin(i_tach_pin), .i_wake_pin(i_wake_pin),
		.i_periph_req(i_periph_req), .i_infrared_event(i_infrared_event),
		.o_group_mgmt_internal(o_group_mgmt_internal), .o_serirq_irq2(o_serirq_irq2),
		.o_mgmt_irq_pin(o_mgmt_irq_pin), .o_wake_event_pin(o_wake_event_pin));
	sea_host_model host (.i_mgmt_pin(o_mgmt_irq_pin), .i_wake_pin(o_wake_event_pin),
		.o_mgmt_line(mgmt_line), .o_wake_line(wake_line));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// ==========================================================
	// access and compare tasks
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		chk($sformatf("reg %h", a), o_rdata, exp);
	endtask : rdchk
	// pin events need the sync pipeline, so wait past it
	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
		@(negedge i_clk);
	endtask : settle
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			end_of_test();
		end
	end
	// ==========================================================
	// test sequence
	initial begin
		{n_fail, total_checks, cyc} = '0;
		{i_reset_n, i_addr, i_wdata, i_wr, i_rd, i_gpio_pin, i_tach_pin} = '0;
		{i_wake_pin, i_periph_req, i_infrared_event} = '0;
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rdchk(SEA_GPIO_CFG, SEA_GPIO_CFG_RST);
		rdchk(SEA_MGMT_PIN_CFG, 8'h01);
		rdchk(SEA_WAKE_PIN_CFG, 8'h01);
		rdchk(8'h3f, 8'h00);
		chk("lines", {6'h00, mgmt_line, wake_line}, 8'h03);
		wr(SEA_MGMT_EN_ONE, 8'h3f);
		wr(SEA_MGMT_EN_TWO, 8'hc0);
		for (int i = 0; i < SEA_NPER; i++) begin
			@(posedge i_clk) i_periph_req <= 6'h01 << i;
			settle(3);
			chk("group", {6'h00, o_group_mgmt_internal, o_serirq_irq2}, 8'h03);
			chk("mgmt line", {7'h00, mgmt_line}, 8'h00);
			wr(SEA_MGMT_ST_ONE, 8'hff);
			rdchk(SEA_MGMT_ST_ONE, 8'h01 << i);
			@(posedge i_clk) i_periph_req <= 6'h00;
			settle(3);
			chk("group off", {7'h00, o_group_mgmt_internal}, 8'h00);
		end
		wr(SEA_MGMT_EN_ONE, 8'h3e);
		@(posedge i_clk) i_periph_req <= 6'h01;
		settle(3);
		chk("masked", {7'h00, o_group_mgmt_internal}, 8'h00);
		@(posedge i_clk) i_periph_req <= 6'h00;
		wr(SEA_MGMT_EN_TWO, 8'hc1);
		@(posedge i_clk) i_infrared_event <= 1'b1;
		@(posedge i_clk) i_infrared_event <= 1'b0;
		settle(3);
		chk("ir group", {7'h00, o_group_mgmt_internal}, 8'h01);
		rdchk(SEA_MGMT_ST_TWO, 8'h01);
		rdchk(SEA_MGMT_ST_TWO, 8'h00);
		@(posedge i_clk) i_gpio_pin <= 8'h01;
		settle(5);
		rdchk(SEA_MGMT_ST_GPIO, 8'h01);
		rdchk(SEA_WAKE_ST_GPIO, 8'h01);
		@(posedge i_clk) i_gpio_pin <= 8'h00;
		settle(5);
		wr(SEA_MGMT_ST_GPIO, 8'h01);
		rdchk(SEA_MGMT_ST_GPIO, 8'h00);
		wr(SEA_GPIO_CFG + 8'h01, 8'h03);
		@(posedge i_clk) i_gpio_pin <= 8'h02;
		settle(5);
		rdchk(SEA_MGMT_ST_GPIO, 8'h00);
		@(posedge i_clk) i_gpio_pin <= 8'h00;
		settle(5);
		rdchk(SEA_MGMT_ST_GPIO, 8'h02);
		wr(SEA_MGMT_EN_GPIO, 8'h02);
		settle(2);
		chk("gpio group", {7'h00, o_group_mgmt_internal}, 8'h01);
		wr(SEA_MGMT_ST_GPIO, 8'hff);
		settle(2);
		chk("gpio clr", {7'h00, o_group_mgmt_internal}, 8'h00);
		wr(SEA_GPIO_CFG + 8'h02, 8'h06);
		for (int e = 0; e < 2; e++) begin
			wr(SEA_MISC_ST, 8'hff);
			wr(SEA_MGMT_ST_GPIO, 8'hff);
			@(posedge i_clk) i_gpio_pin <= (e == 0) ? 8'h04 : 8'h00;
			settle(5);
			rdchk(SEA_MISC_ST, 8'h04);
			rdchk(SEA_MGMT_ST_GPIO, 8'h04);
			rdchk(SEA_GPIO_DATA, (e == 0) ? 8'h02 : 8'h06);
		end
		wr(SEA_MGMT_EN_GPIO, 8'h04);
		settle(2);
		chk("ee group", {7'h00, o_group_mgmt_internal}, 8'h01);
		wr(SEA_MGMT_EN_GPIO, 8'h00);
		@(posedge i_clk) i_tach_pin <= 2'h1;
		settle(5);
		rdchk(SEA_MGMT_ST_TACH, 8'h01);
		wr(SEA_MGMT_EN_TACH, 8'h01);
		settle(2);
		chk("tach group", {7'h00, o_group_mgmt_internal}, 8'h01);
		wr(SEA_MGMT_EN_TACH, 8'h00);
		settle(2);
		chk("tach masked", {7'h00, o_group_mgmt_internal}, 8'h00);
		rdchk(SEA_WAKE_ST_THREE, 8'h01);
		wr(SEA_WAKE_ST_THREE, 8'h03);
		wr(SEA_WAKE_EN_ONE, 8'h01);
		@(posedge i_clk) i_wake_pin <= 5'h01;
		settle(5);
		rdchk(SEA_WAKE_ST_ONE, 8'h01);
		rdchk(SEA_WAKE_GLOBAL, 8'h02);
		chk("wake off", {7'h00, wake_line}, 8'h01);
		wr(SEA_WAKE_GLOBAL, 8'h01);
		settle(2);
		chk("wake on", {7'h00, wake_line}, 8'h00);
		wr(SEA_WAKE_GLOBAL, 8'h03);
		rdchk(SEA_WAKE_GLOBAL, 8'h03);
		wr(SEA_WAKE_ST_ONE, 8'h01);
		wr(SEA_WAKE_GLOBAL, 8'h03);
		rdchk(SEA_WAKE_GLOBAL, 8'h01);
		chk("wake idle", {7'h00, wake_line}, 8'h01);
		wr(SEA_MGMT_PIN_CFG, 8'h83);
		@(posedge i_clk) i_periph_req <= 6'h02;
		wr(SEA_MGMT_EN_TWO, 8'he0);
		settle(3);
		chk("pp pin", {6'h00, o_mgmt_irq_pin}, 8'h03);
		rdchk(SEA_WAKE_ST_THREE, 8'h08);
		wr(SEA_WAKE_EN_THREE, 8'h08);
		wr(SEA_WAKE_PIN_CFG, 8'h83);
		settle(3);
		chk("routed wake", {6'h00, o_wake_event_pin}, 8'h03);
		@(posedge i_clk) i_periph_req <= 6'h00;
		settle(3);
		wr(SEA_WAKE_ST_THREE, 8'h08);
		rdchk(SEA_WAKE_ST_THREE, 8'h00);
		end_of_test();
	end
endmodule : sea_aggregator_bench
bind sea_aggregator sea_aggregator_props chk_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_group_mgmt_internal(o_group_mgmt_internal), .o_serirq_irq2(o_serirq_irq2),
	.o_mgmt_irq_pin(o_mgmt_irq_pin), .o_wake_event_pin(o_wake_event_pin));
`default_nettype wire
